/* File: shared/pamx_consts.vh */
// Constants for the port A upper-line function map
`ifndef PAMX_CONSTS_VH
`define PAMX_CONSTS_VH

// Function select codes per line (2 bits)
`define PAMX_SEL_GPIO 2'h0
`define PAMX_SEL_FN_A 2'h1
`define PAMX_SEL_FN_B 2'h2
`define PAMX_SEL_FN_C 2'h3

// Cell-bus octet stream
`define PAMX_OCTET_W 8
`define PAMX_CELL_OCTETS 6'h35
`define PAMX_CELL_LAST 6'h34
`define PAMX_FIFO_DEPTH 16
`define PAMX_FIFO_AW 4

// Module number layout
`define PAMX_MODNUM_W 6
`define PAMX_MODNUM_DIR_BIT 5
`define PAMX_MODNUM_DIR_TX 1'h0
`define PAMX_MODNUM_DIR_RX 1'h1

// Line positions within the seven-line group (line 6 is index 0)
`define PAMX_LINE_COUNT 7
`define PAMX_IDX_L12 6
`define PAMX_IDX_L11 5
`define PAMX_IDX_L10 4
`define PAMX_IDX_L9 3
`define PAMX_IDX_L8 2
`define PAMX_IDX_L7 1
`define PAMX_IDX_L6 0

`endif

/* File: hw/pamx_fifo.v */
// No logic of its own: the octet FIFO is kept beside the port map in one design file

/* File: hw/pamx_port_map.v */
// Pin-function map for port A lines 12 down to 6
`timescale 1ns/1ps
`default_nettype none
`include "pamx_consts.vh"
module pamx_port_map (
    input wire i_ref_clk,
    input wire i_rst,
    // Per-line function select, two bits per line, line 6 in bits 1:0
    input wire [13:0] i_line_sel,
    // Pad side: line 6 is bit 0, line 12 is bit 6
    input wire [6:0] i_pad_in,
    output reg [6:0] o_pad_out,
    output reg [6:0] o_pad_oe,
    // General-purpose I/O
    input wire [6:0] i_gpio_out,
    input wire [6:0] i_gpio_oe,
    output wire [6:0] o_gpio_in,
    // Cell-bus receive: upper five bits arrive on other lines, synchronised here
    input wire [4:0] i_cell_rx_hi,
    input wire i_phy_rx_output_enable,
    input wire i_cell_sof,
    output wire [7:0] o_cell_octet,
    output wire o_cell_valid,
    input wire i_cell_ready,
    output wire o_cell_first,
    output wire o_cell_overrun,
    // Serial DMA engine ownership
    input wire [4:0] i_dma_sub_block,
    input wire i_dma_rx_section,
    input wire i_dma_xfer_err,
    output reg [5:0] o_dma_module_number,
    output reg [5:0] o_dma_err_module_number,
    output reg o_dma_err_valid,
    // Management serial channel two
    input wire i_mgmt_tx_data,
    output reg o_mgmt_rx_data,
    output reg o_mgmt_sync_in,
    // TDM channel A1
    input wire i_tdm_nibble_tx_bit0,
    output reg o_tdm_nibble_rx_bit0,
    output reg o_tdm_serial_rx_line,
    output reg o_tdm_tx_frame_sync,
    output reg o_tdm_rx_frame_sync
);
    reg [6:0] pad_meta_reg;
    reg [6:0] pad_sync_reg;
    reg [4:0] hi_meta_reg;
    reg [4:0] hi_sync_reg;
    reg en_meta_reg;
    reg en_sync_reg;
    reg [5:0] octet_cnt_reg;
    reg overrun_reg;
    wire [1:0] sel [0:6];
    wire [7:0] octet;
    wire cell_first;
    wire fifo_ready;
    wire take;

    genvar g;
    generate
        for (g = 0; g < `PAMX_LINE_COUNT; g = g + 1) begin : gen_sel
            assign sel[g] = i_line_sel[2*g+1:2*g];
        end
    endgenerate

    // Pads are asynchronous to the reference clock
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            pad_meta_reg <= 7'h00;
            pad_sync_reg <= 7'h00;
            hi_meta_reg <= 5'h00;
            hi_sync_reg <= 5'h00;
            en_meta_reg <= 1'h0;
            en_sync_reg <= 1'h0;
        end else begin
            pad_meta_reg <= i_pad_in;
            pad_sync_reg <= pad_meta_reg;
            hi_meta_reg <= i_cell_rx_hi;
            hi_sync_reg <= hi_meta_reg;
            en_meta_reg <= i_phy_rx_output_enable;
            en_sync_reg <= en_meta_reg;
        end
    end

    assign o_gpio_in = pad_sync_reg;

    // Octet assembled MSB first from upper lines, bits 2..0 from lines 12..10
    assign octet = {hi_sync_reg, pad_sync_reg[`PAMX_IDX_L12], pad_sync_reg[`PAMX_IDX_L11],
                    pad_sync_reg[`PAMX_IDX_L10]};

    // Data is sampled only while the PHY is enabled; others hold their pins released
    assign take = en_sync_reg &&
                  sel[`PAMX_IDX_L12] == `PAMX_SEL_FN_A &&
                  sel[`PAMX_IDX_L11] == `PAMX_SEL_FN_A &&
                  sel[`PAMX_IDX_L10] == `PAMX_SEL_FN_A;
    assign cell_first = (octet_cnt_reg == 6'h00);

    // Octet counter marks cell boundaries; a start pulse realigns it
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            octet_cnt_reg <= 6'h00;
            overrun_reg <= 1'h0;
        end else begin
            if (take && fifo_ready) begin
                if (i_cell_sof) begin
                    octet_cnt_reg <= 6'h01;
                end else if (octet_cnt_reg == `PAMX_CELL_LAST) begin
                    octet_cnt_reg <= 6'h00;
                end else begin
                    octet_cnt_reg <= octet_cnt_reg + 6'h01;
                end
            end
            // Sticky: pins cannot be stalled, so a full buffer loses octets
            if (take && !fifo_ready) begin
                overrun_reg <= 1'h1;
            end
        end
    end
    assign o_cell_overrun = overrun_reg;

    // Ninth bit carries the start-of-cell marker through the buffer
    wire [8:0] fifo_out;
    pamx_fifo #(
        .WIDTH(`PAMX_OCTET_W + 1),
        .DEPTH(`PAMX_FIFO_DEPTH),
        .AW(`PAMX_FIFO_AW)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_wr_data({cell_first | i_cell_sof, octet}),
        .i_wr_valid(take),
        .o_wr_ready(fifo_ready),
        .o_rd_data(fifo_out),
        .o_rd_valid(o_cell_valid),
        .i_rd_ready(i_cell_ready)
    );
    assign o_cell_octet = fifo_out[7:0];
    assign o_cell_first = fifo_out[8];

    // Module number and error capture
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_dma_module_number <= 6'h00;
            o_dma_err_module_number <= 6'h00;
            o_dma_err_valid <= 1'h0;
        end else begin
            o_dma_module_number <= {i_dma_rx_section, i_dma_sub_block};
            if (i_dma_xfer_err) begin
                o_dma_err_module_number <= {i_dma_rx_section, i_dma_sub_block};
                o_dma_err_valid <= 1'h1;
            end
        end
    end

    // Pad drive: dedicated outputs or GPIO per line
    always @* begin
        o_pad_out = i_gpio_out;
        o_pad_oe = i_gpio_oe;
        // Lines 12..10 carry number bits 3, 4, 5 when selected as outputs
        if (sel[`PAMX_IDX_L12] == `PAMX_SEL_FN_B) begin
            o_pad_out[`PAMX_IDX_L12] = o_dma_module_number[3];
            o_pad_oe[`PAMX_IDX_L12] = 1'b1;
        end else if (sel[`PAMX_IDX_L12] != `PAMX_SEL_GPIO) begin
            o_pad_out[`PAMX_IDX_L12] = 1'b0;
            o_pad_oe[`PAMX_IDX_L12] = 1'b0;
        end
        if (sel[`PAMX_IDX_L11] == `PAMX_SEL_FN_B) begin
            o_pad_out[`PAMX_IDX_L11] = o_dma_module_number[4];
            o_pad_oe[`PAMX_IDX_L11] = 1'b1;
        end else if (sel[`PAMX_IDX_L11] != `PAMX_SEL_GPIO) begin
            o_pad_out[`PAMX_IDX_L11] = 1'b0;
            o_pad_oe[`PAMX_IDX_L11] = 1'b0;
        end
        if (sel[`PAMX_IDX_L10] == `PAMX_SEL_FN_B) begin
            o_pad_out[`PAMX_IDX_L10] = o_dma_module_number[`PAMX_MODNUM_DIR_BIT];
            o_pad_oe[`PAMX_IDX_L10] = 1'b1;
        end else if (sel[`PAMX_IDX_L10] != `PAMX_SEL_GPIO) begin
            o_pad_out[`PAMX_IDX_L10] = 1'b0;
            o_pad_oe[`PAMX_IDX_L10] = 1'b0;
        end
        // Line 9: management transmit (A) or nibble transmit bit 0 (B)
        if (sel[`PAMX_IDX_L9] == `PAMX_SEL_FN_A) begin
            o_pad_out[`PAMX_IDX_L9] = i_mgmt_tx_data;
            o_pad_oe[`PAMX_IDX_L9] = 1'b1;
        end else if (sel[`PAMX_IDX_L9] == `PAMX_SEL_FN_B) begin
            o_pad_out[`PAMX_IDX_L9] = i_tdm_nibble_tx_bit0;
            o_pad_oe[`PAMX_IDX_L9] = 1'b1;
        end else if (sel[`PAMX_IDX_L9] == `PAMX_SEL_FN_C) begin
            o_pad_out[`PAMX_IDX_L9] = 1'b0;
            o_pad_oe[`PAMX_IDX_L9] = 1'b0;
        end
        // Lines 8..6 are inputs under any dedicated function
        if (sel[`PAMX_IDX_L8] != `PAMX_SEL_GPIO) begin
            o_pad_out[`PAMX_IDX_L8] = 1'b0;
            o_pad_oe[`PAMX_IDX_L8] = 1'b0;
        end
        if (sel[`PAMX_IDX_L7] != `PAMX_SEL_GPIO) begin
            o_pad_out[`PAMX_IDX_L7] = 1'b0;
            o_pad_oe[`PAMX_IDX_L7] = 1'b0;
        end
        if (sel[`PAMX_IDX_L6] != `PAMX_SEL_GPIO) begin
            o_pad_out[`PAMX_IDX_L6] = 1'b0;
            o_pad_oe[`PAMX_IDX_L6] = 1'b0;
        end
    end

    // Dedicated inputs route to their peripheral only when selected, else idle low
    always @* begin
        o_mgmt_rx_data = 1'b0;
        o_tdm_nibble_rx_bit0 = 1'b0;
        o_tdm_serial_rx_line = 1'b0;
        o_mgmt_sync_in = 1'b0;
        o_tdm_tx_frame_sync = 1'b0;
        o_tdm_rx_frame_sync = 1'b0;
        case (sel[`PAMX_IDX_L8])
            `PAMX_SEL_FN_A: o_mgmt_rx_data = pad_sync_reg[`PAMX_IDX_L8];
            `PAMX_SEL_FN_B: o_tdm_nibble_rx_bit0 = pad_sync_reg[`PAMX_IDX_L8];
            `PAMX_SEL_FN_C: o_tdm_serial_rx_line = pad_sync_reg[`PAMX_IDX_L8];
            default: o_mgmt_rx_data = 1'b0;
        endcase
        case (sel[`PAMX_IDX_L7])
            `PAMX_SEL_FN_A: o_mgmt_sync_in = pad_sync_reg[`PAMX_IDX_L7];
            `PAMX_SEL_FN_B: o_tdm_tx_frame_sync = pad_sync_reg[`PAMX_IDX_L7];
            default: o_mgmt_sync_in = 1'b0;
        endcase
        if (sel[`PAMX_IDX_L6] != `PAMX_SEL_GPIO) begin
            o_tdm_rx_frame_sync = pad_sync_reg[`PAMX_IDX_L6];
        end
    end
endmodule

// Synchronous valid/ready FIFO for the cell-bus octet stream
module pamx_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire i_ref_clk,
    input wire i_rst,
    input wire [WIDTH-1:0] i_wr_data,
    input wire i_wr_valid,
    output wire o_wr_ready,
    output reg [WIDTH-1:0] o_rd_data,
    output wire o_rd_valid,
    input wire i_rd_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr_reg;
    reg [AW:0] rd_ptr_reg;
    wire full;
    wire empty;
    wire do_wr;
    wire do_rd;
    wire [AW:0] rd_ptr_next;

    assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    assign empty = (wr_ptr_reg == rd_ptr_reg);
    assign o_wr_ready = ~full;
    assign o_rd_valid = ~empty;
    assign do_wr = i_wr_valid & ~full;
    assign do_rd = i_rd_ready & ~empty;
    assign rd_ptr_next = rd_ptr_reg + {{AW{1'b0}}, 1'b1};

    always @(posedge i_ref_clk) begin
        if (do_wr) begin
            mem[wr_ptr_reg[AW-1:0]] <= i_wr_data;
        end
    end

    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr_reg <= {(AW+1){1'b0}};
            rd_ptr_reg <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_reg <= wr_ptr_reg + {{AW{1'b0}}, 1'b1};
            end
            if (do_rd) begin
                rd_ptr_reg <= rd_ptr_next;
            end
        end
    end

    // Show-ahead data register; the write-before-read case is covered by the bypass
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rd_data <= {WIDTH{1'b0}};
        end else if (do_rd) begin
            if (rd_ptr_next == wr_ptr_reg && do_wr) begin
                o_rd_data <= i_wr_data;
            end else begin
                o_rd_data <= mem[rd_ptr_next[AW-1:0]];
            end
        end else if (empty && do_wr) begin
            o_rd_data <= i_wr_data;
        end
    end
endmodule
`default_nettype wire

/* File: verification/pamx_chk.sv */
// Assertions on the port map's pins
`timescale 1ns/1ps
`default_nettype none
module pamx_chk (
    input wire i_ref_clk,
    input wire i_rst,
    input wire [13:0] i_line_sel,
    input wire [6:0] i_pad_in,
    input wire [6:0] o_pad_out,
    input wire [6:0] o_pad_oe,
    input wire [6:0] i_gpio_out,
    input wire [6:0] i_gpio_oe,
    input wire [6:0] o_gpio_in,
    input wire [4:0] i_dma_sub_block,
    input wire i_dma_rx_section,
    input wire i_dma_xfer_err,
    input wire [5:0] o_dma_module_number,
    input wire [5:0] o_dma_err_module_number,
    input wire o_dma_err_valid,
    input wire i_mgmt_tx_data,
    input wire i_tdm_nibble_tx_bit0,
    input wire [7:0] o_cell_octet,
    input wire o_cell_valid,
    input wire i_cell_ready,
    input wire o_cell_overrun
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    wire [5:0] own = {i_dma_rx_section, i_dma_sub_block};
    wire [5:0] mn = o_dma_module_number;
    a_number_follows: assert property (!$past(i_rst) |-> mn == $past(own))
        else $error("module number lags its owner");
    a_err_capture: assert property (i_dma_xfer_err |=> o_dma_err_valid && o_dma_err_module_number == $past(own))
        else $error("error capture wrong");
    a_err_holds: assert property (o_dma_err_valid && !i_dma_xfer_err |=> $stable(o_dma_err_module_number))
        else $error("error capture moved");
    a_mgmt_tx_drive: assert property (i_line_sel[7:6] == 2'h1 |-> o_pad_oe[3] && o_pad_out[3] == i_mgmt_tx_data)
        else $error("line 9 not driving mgmt data");
    a_nibble_drive: assert property (i_line_sel[7:6] == 2'h2 |-> o_pad_oe[3] && o_pad_out[3] == i_tdm_nibble_tx_bit0)
        else $error("line 9 not driving nibble bit");
    a_inputs_float: assert property ((o_pad_oe[2:0] & {|i_line_sel[5:4], |i_line_sel[3:2], |i_line_sel[1:0]}) == 3'h0)
        else $error("input line driven");
    a_number_pins: assert property (i_line_sel[13:8] == 6'h2a |-> o_pad_oe[6:4] == 3'h7 && o_pad_out[6:4] == {mn[3], mn[4], mn[5]})
        else $error("number bits misplaced");
    a_gpio_pass: assert property (i_line_sel == 14'h0 |-> o_pad_out == i_gpio_out && o_pad_oe == i_gpio_oe)
        else $error("gpio not passed");
    a_pad_sync: assert property (!$past(i_rst) && !$past(i_rst, 2) |-> o_gpio_in == $past(i_pad_in, 2))
        else $error("pad sync latency");
    a_octet_stands: assert property (o_cell_valid && !i_cell_ready |=> o_cell_valid && $stable(o_cell_octet))
        else $error("octet dropped while stalled");
    c_overrun: cover property ($rose(o_cell_overrun));
    c_pop: cover property (o_cell_valid && i_cell_ready);
    c_err: cover property (i_dma_xfer_err);
endmodule
bind pamx_port_map pamx_chk i_pamx_chk (.*);
`default_nettype wire

/* File: verification/pamx_phy_model.sv */
// Cell-bus PHY: counting octets on the receive lines
`timescale 1ns/1ps
`default_nettype none
module pamx_phy_model (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_en,
    output logic [7:0] o_rx_data
);
    logic [7:0] cnt_reg;
    // Released lines show the inverse so a stale octet cannot pass
    assign o_rx_data = i_en ? cnt_reg : ~(cnt_reg - 8'h01);
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst)
            cnt_reg <= 8'h00;
        else if (i_en)
            cnt_reg <= cnt_reg + 8'h01;
    end
endmodule
`default_nettype wire

/* File: verification/pamx_port_map_tb.sv */
// Testbench for the port A upper-line map
`timescale 1ns/1ps
`default_nettype none
`include "pamx_consts.vh"
module pamx_port_map_tb;
    typedef struct packed {
        logic [13:0] sel;
        logic [6:0] go;
        logic [6:0] goe;
        logic [1:0] tx;
        logic [5:0] own;
        logic [3:0] plo;
        logic [6:0] eo;
        logic [6:0] eoe;
        logic [5:0] ein;
    } pamx_row_t;
    pamx_row_t rows [0:9] = '{
        '{14'h0000, 7'h55, 7'h7f, 2'h0, 6'h00, 4'h7, 7'h55, 7'h7f, 6'h00},
        '{14'h0040, 7'h00, 7'h00, 2'h2, 6'h00, 4'h0, 7'h08, 7'h08, 6'h00},
        '{14'h0080, 7'h00, 7'h00, 2'h1, 6'h00, 4'h0, 7'h08, 7'h08, 6'h00},
        '{14'h00c0, 7'h00, 7'h7f, 2'h3, 6'h00, 4'h0, 7'h00, 7'h77, 6'h00},
        '{14'h2a00, 7'h00, 7'h00, 2'h0, 6'h18, 4'h0, 7'h60, 7'h70, 6'h00},
        '{14'h2a00, 7'h00, 7'h00, 2'h0, 6'h28, 4'h0, 7'h50, 7'h70, 6'h00},
        '{14'h0015, 7'h00, 7'h7f, 2'h0, 6'h00, 4'h6, 7'h00, 7'h78, 6'h24},
        '{14'h002a, 7'h00, 7'h7f, 2'h0, 6'h00, 4'h7, 7'h00, 7'h78, 6'h13},
        '{14'h003f, 7'h00, 7'h7f, 2'h0, 6'h00, 4'h7, 7'h00, 7'h78, 6'h09},
        '{14'h3f00, 7'h00, 7'h7f, 2'h0, 6'h00, 4'h5, 7'h00, 7'h0f, 6'h00}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [13:0] sel = 14'h0;
    logic [6:0] go = 7'h0;
    logic [6:0] goe = 7'h0;
    logic [1:0] tx = 2'h0;
    logic [5:0] own = 6'h0;
    logic [3:0] plo = 4'h0;
    logic err = 1'b0;
    logic en = 1'b0;
    logic rdy = 1'b0;
    logic sof = 1'b0;
    wire [7:0] phy;
    wire [6:0] po;
    wire [6:0] poe;
    wire [6:0] gin;
    wire [7:0] oct;
    wire [5:0] mn;
    wire [5:0] emn;
    wire [5:0] fin;
    wire val;
    wire fst;
    wire ovr;
    wire ev;
    int n_mismatch = 0;
    int checks = 0;
    int npop = 0;
    always #2.5 clk = ~clk;
    pamx_phy_model i_pamx_phy_model (.i_ref_clk(clk), .i_rst(rst), .i_en(en), .o_rx_data(phy));
    pamx_port_map i_pamx_port_map (.i_ref_clk(clk), .i_rst(rst), .i_line_sel(sel),
        .i_pad_in({phy[2:0], plo}), .o_pad_out(po), .o_pad_oe(poe), .i_gpio_out(go),
        .i_gpio_oe(goe), .o_gpio_in(gin), .i_cell_rx_hi(phy[7:3]), .i_phy_rx_output_enable(en),
        .i_cell_sof(sof), .o_cell_octet(oct), .o_cell_valid(val), .i_cell_ready(rdy),
        .o_cell_first(fst), .o_cell_overrun(ovr), .i_dma_sub_block(own[4:0]),
        .i_dma_rx_section(own[5]), .i_dma_xfer_err(err), .o_dma_module_number(mn),
        .o_dma_err_module_number(emn), .o_dma_err_valid(ev), .i_mgmt_tx_data(tx[1]),
        .o_mgmt_rx_data(fin[5]), .i_tdm_nibble_tx_bit0(tx[0]), .o_tdm_nibble_rx_bit0(fin[4]),
        .o_tdm_serial_rx_line(fin[3]), .o_mgmt_sync_in(fin[2]), .o_tdm_tx_frame_sync(fin[1]),
        .o_tdm_rx_frame_sync(fin[0]));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic complete_run;
        if (n_mismatch == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask
    always @(posedge clk) begin
        if (!rst && val === 1'b1 && rdy) begin
            chk("octet", npop[7:0], oct);
            chk("first", (npop % `PAMX_CELL_OCTETS) == 0 || npop == 60, fst);
            npop++;
        end
    end
    initial begin
        #10000;
        n_mismatch++;
        complete_run();
    end
    task automatic stream(input int n);
        en <= 1'b1;
        cycles(n);
        en <= 1'b0;
        cycles(6);
    endtask
    initial begin
        cycles(12);
        chk("reset", 16'h0, {mn, emn, ev, ovr, val});
        rst <= 1'b0;
        for (int i = 0; i <= 9; i++) begin
            {sel, go, goe, tx, own, plo} <= rows[i][59:20];
            cycles(4);
            #1;
            chk("pad_out", rows[i].eo, po & rows[i].eoe);
            chk("pad_oe", rows[i].eoe, poe);
            chk("rx_fn", rows[i].ein, fin);
            chk("gpio_in", plo, gin[3:0]);
            cycles(1);
        end
        own <= 6'h33;
        err <= 1'b1;
        cycles(1);
        err <= 1'b0;
        own <= 6'h05;
        cycles(1);
        #1;
        chk("err_num", 6'h33, emn);
        chk("err_valid", 1'b1, ev);
        chk("number", 6'h05, mn);
        cycles(1);
        // Both cell rows land: octet index 53 starts the next cell
        sel <= 14'h1500;
        rdy <= 1'b1;
        stream(54);
        chk("pops", 54, npop);
        chk("overrun", 1'b0, ovr);
        // Far side stalls: sixteen kept, rest refused
        rdy <= 1'b0;
        // Start marker taken with octet 60 restarts the cell count
        fork
            stream(20);
            begin
                cycles(8);
                sof <= 1'b1;
                cycles(1);
                sof <= 1'b0;
            end
        join
        chk("overrun", 1'b1, ovr);
        rdy <= 1'b1;
        for (int k = 0; k < 40 && npop < 70; k++)
            cycles(1);
        cycles(3);
        chk("pops", 70, npop);
        chk("valid", 1'b0, val);
        rst <= 1'b1;
        cycles(1);
        #1;
        chk("reset", 16'h0, {mn, emn, ev, ovr, val});
        complete_run();
    end
endmodule
`default_nettype wire
